//--- src/pse_regs_map.vh
`ifndef PSE_REGS_MAP_VH
`define PSE_REGS_MAP_VH

// command codes
`define CMD_POWER_STATE 8'h10
`define CMD_STRAP_READBACK 8'h11
`define CMD_MODE_SELECT 8'h12

// reset values
`define MODE_SELECT_RESET 8'h00
`define BYTE_ZERO 8'h00

// channel mode field codes
`define MODE_OFF 2'h0
`define MODE_MANUAL 2'h1
`define MODE_SEMIAUTO 2'h2
`define MODE_AUTO 2'h3
`define MODE_FIELD_W 2

// slave address layout
`define ADDR_PREFIX 2'h1
`define ADDR_BROADCAST 7'h7F
`define RW_READ 1'b1

// strap readback field positions
`define READBACK_STRAP_HI 6
`define READBACK_STRAP_LO 3
`define READBACK_BANK_BIT 2

// requested and assigned class codes
`define CLASS_0_RESERVED 4'h5
`define CLASS_0 4'h6
`define CLASS_3 4'h3
`define CLASS_4 4'h4
`define CLASS_5_SS 4'h8
`define CLASS_8_SS 4'hB
`define CLASS_4PLUS_T1 4'hC
`define CLASS_5_DS 4'hD
`define CLASS_NONE 4'h0

// serial byte framing
`define BITS_PER_BYTE 4'h8
`define BITCNT_ZERO 4'h0
`define BITCNT_STEP 4'h1
`define PTR_STEP 8'h01
`define TX_MSB 3'h7

`endif

//--- src/pse_channel_flag.v
`timescale 1ns/1ps
module pse_channel_flag (
  input wire ref_clk_in, // device clock
  input wire reset_in, // synchronous reset, active high
  input wire ce_in, // clock enable, freezes state when low
  input wire channel_on_in, // channel powered and not in off mode
  input wire turn_on_done_in, // turn-on sequence complete
  input wire drain_below_pg_in, // drain sense under power-good threshold
  input wire pg_allow_in, // pairing lets power-good be set now
  output reg channel_on_flag_out, // channel-on flag
  output reg power_good_flag_out, // latched power-good flag
  output reg channel_on_change_event_out, // pulse on channel-on change
  output reg power_good_change_event_out // pulse on power-good change
);

  wire next_on;
  wire next_pg;

  assign next_on = channel_on_in;
  // power-good latches and only an off channel lets it go
  assign next_pg = channel_on_in & (power_good_flag_out |
    (turn_on_done_in & drain_below_pg_in & pg_allow_in));

  always @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      channel_on_flag_out <= 1'b0;
      power_good_flag_out <= 1'b0;
      channel_on_change_event_out <= 1'b0;
      power_good_change_event_out <= 1'b0;
    end
    else if (ce_in)
    begin
      channel_on_flag_out <= next_on;
      power_good_flag_out <= next_pg;
      channel_on_change_event_out <= next_on ^ channel_on_flag_out;
      power_good_change_event_out <= next_pg ^ power_good_flag_out;
    end
  end

endmodule

//--- src/pse_channel_status_mode_regs.v
// Functional notes
// - class 4+ powered at lowest allocation reports type-1 limited 4+
// - class 0 discovery gets assigned class 3 once the channel is powered
// - power state byte read-only at 10h; channel bits clear on turn-off
// - upper nibble power-good: on and drain under threshold at turn-on
// - power-good latches after turn-on, clears only on turn-off or reset
// - lower nibble channel-on flags, channel 1 in bit 0
// - four-pair dual signature channels update their flags independently
// - single signature 4-pair: power-good set after both channels done
// - four-pair dual signature raises change events per channel
// - strap readback at 11h: bits 6..3 strap levels, 7,1,0 zero
// - bit 2 fixed bank bit, 0 for channels 1-4; reads 0 in config B
// - slave address 01, straps A4 first, bank bit; all-ones is broadcast
// - mode select at 12h read/write reset 0, two bits per channel
// - mode field: 00 off, 01 manual, 10 semiauto, 11 auto
// - entering off mode with a falling flag raises its change event
`timescale 1ns/1ps
`include "pse_regs_map.vh"
module pse_channel_status_mode_regs #(
  parameter [0:0] BANK_SELECT = 1'b0 // internally fixed bank bit
) (
  input wire ref_clk_in, // 40 MHz device clock
  input wire reset_in, // synchronous reset, active high
  input wire ce_in, // clock enable, freezes state when low
  input wire config_b_in, // configuration B: bank bit forced to 0
  input wire [3:0] address_strap_pins_in, // strap levels, bit 3 is A4
  input wire scl_in, // serial clock, synchronous to ref_clk_in
  input wire sda_in, // serial data line level
  output reg sda_out, // serial data drive level, always 0
  output reg sda_oe_n_out, // low while pulling serial data low
  input wire [3:0] channel_on_in, // channel powered by sequencer
  input wire [3:0] turn_on_done_in, // turn-on complete per channel
  input wire [3:0] drain_sense_pin_in, // drain under power-good threshold
  input wire [1:0] four_pair_wired_in, // pairs 1-2 and 3-4 wired as a port
  input wire [1:0] single_signature_in, // pair carries single-signature load
  input wire [3:0] alloc_lowest_in, // allocation at lowest 15.5W level
  input wire [15:0] measured_class_in, // measured class, 4 bits a channel
  output wire [3:0] power_good_flags_out, // latched power-good flags
  output wire [3:0] channel_on_flags_out, // channel-on flags
  output wire [3:0] channel_on_change_event_out, // pulse, on flag changed
  output wire [3:0] power_good_change_event_out, // pulse, good flag changed
  output reg [7:0] channel_mode_out, // mode select register
  output reg [15:0] requested_class_out, // reported requested class
  output reg [15:0] assigned_class_out // assigned class while powered
);

  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_CMD = 3'h2;
  localparam ST_WDATA = 3'h3;
  localparam ST_RDATA = 3'h4;
  localparam ST_RACK = 3'h5;

  reg [3:0] strap_q;
  reg scl_q;
  reg sda_q;
  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg in_ack;
  reg [7:0] shift;
  reg [7:0] pointer;
  reg [7:0] tx_byte;
  reg [7:0] channel_mode_select;

  wire scl_rise;
  wire scl_fall;
  wire start_seen;
  wire stop_seen;
  wire bank_bit;
  wire [6:0] own_address;
  wire addr_match;
  wire [7:0] channel_power_state;
  wire [7:0] strap_address_readback;
  wire [3:0] mode_on;
  wire [3:0] pg_ready;
  wire [3:0] pg_allow;
  wire [7:0] next_pointer;

  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign start_seen = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_seen = scl_in & scl_q & ~sda_q & sda_in;

  assign bank_bit = config_b_in ? 1'b0 : BANK_SELECT;
  assign own_address = {`ADDR_PREFIX, strap_q, bank_bit};
  // broadcast is taken regardless of straps
  assign addr_match = (shift[7:1] == own_address) |
    (shift[7:1] == `ADDR_BROADCAST);
  assign next_pointer = pointer + `PTR_STEP;

  assign channel_power_state = {power_good_flags_out,
    channel_on_flags_out};
  assign strap_address_readback = {1'b0, strap_q, bank_bit, 2'b00};

  function [7:0] read_byte;
    input [7:0] ptr;
    input [7:0] pstate;
    input [7:0] readback;
    input [7:0] mode;
    begin
      case (ptr)
        `CMD_POWER_STATE: read_byte = pstate;
        `CMD_STRAP_READBACK: read_byte = readback;
        `CMD_MODE_SELECT: read_byte = mode;
        default: read_byte = `BYTE_ZERO;
      endcase
    end
  endfunction

  function high_class;
    input [3:0] cls;
    begin
      high_class = (cls == `CLASS_4) | (cls == `CLASS_5_DS) |
        ((cls >= `CLASS_5_SS) & (cls <= `CLASS_8_SS));
    end
  endfunction

  // strap levels are caught while reset is held and kept afterwards
  always @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      strap_q <= address_strap_pins_in;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1)
    begin : g_chan
      // a channel in off mode is treated as turned off at once
      assign mode_on[ch] = channel_on_in[ch] &
        (channel_mode_select[2*ch+1:2*ch] != `MODE_OFF);
      assign pg_ready[ch] = mode_on[ch] & turn_on_done_in[ch] &
        drain_sense_pin_in[ch];
      // single signature holds power-good until the partner is ready too,
      // so both flags rise together and only one interrupt follows
      assign pg_allow[ch] = ~(four_pair_wired_in[ch/2] &
        single_signature_in[ch/2]) | pg_ready[ch^1];

      pse_channel_flag u_flag (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .channel_on_in(mode_on[ch]),
        .turn_on_done_in(turn_on_done_in[ch]),
        .drain_below_pg_in(drain_sense_pin_in[ch]),
        .pg_allow_in(pg_allow[ch]),
        .channel_on_flag_out(channel_on_flags_out[ch]),
        .power_good_flag_out(power_good_flags_out[ch]),
        .channel_on_change_event_out(channel_on_change_event_out[ch]),
        .power_good_change_event_out(power_good_change_event_out[ch])
      );

      always @(posedge ref_clk_in)
      begin
        if (reset_in)
        begin
          requested_class_out[4*ch+3:4*ch] <= `CLASS_NONE;
          assigned_class_out[4*ch+3:4*ch] <= `CLASS_NONE;
        end
        else if (ce_in)
        begin
          if (mode_on[ch] & alloc_lowest_in[ch] &
            high_class(measured_class_in[4*ch+3:4*ch]))
            requested_class_out[4*ch+3:4*ch] <= `CLASS_4PLUS_T1;
          else
            requested_class_out[4*ch+3:4*ch] <=
              measured_class_in[4*ch+3:4*ch];
          if (~mode_on[ch])
            assigned_class_out[4*ch+3:4*ch] <= `CLASS_NONE;
          else if ((measured_class_in[4*ch+3:4*ch] == `CLASS_0) |
            (measured_class_in[4*ch+3:4*ch] == `CLASS_0_RESERVED))
            assigned_class_out[4*ch+3:4*ch] <= `CLASS_3;
          else
            assigned_class_out[4*ch+3:4*ch] <=
              measured_class_in[4*ch+3:4*ch];
        end
      end
    end
  endgenerate

  always @*
  begin
    channel_mode_out = channel_mode_select;
  end

  // serial slave: bits taken on scl rise, data driven on scl fall
  always @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      state <= ST_IDLE;
      bit_cnt <= `BITCNT_ZERO;
      in_ack <= 1'b0;
      shift <= `BYTE_ZERO;
      pointer <= `BYTE_ZERO;
      tx_byte <= `BYTE_ZERO;
      channel_mode_select <= `MODE_SELECT_RESET;
      sda_out <= 1'b0;
      sda_oe_n_out <= 1'b1;
    end
    else if (ce_in)
    begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (start_seen)
      begin
        state <= ST_ADDR;
        bit_cnt <= `BITCNT_ZERO;
        in_ack <= 1'b0;
        sda_oe_n_out <= 1'b1;
      end
      else if (stop_seen)
      begin
        state <= ST_IDLE;
        in_ack <= 1'b0;
        sda_oe_n_out <= 1'b1;
      end
      else
      begin
        case (state)
          ST_ADDR, ST_CMD, ST_WDATA:
          begin
            if (scl_rise & ~in_ack)
            begin
              shift <= {shift[6:0], sda_in};
              bit_cnt <= bit_cnt + `BITCNT_STEP;
            end
            else if (scl_fall & in_ack)
            begin
              in_ack <= 1'b0;
              sda_oe_n_out <= 1'b1;
            end
            else if (scl_fall & (bit_cnt == `BITS_PER_BYTE))
            begin
              bit_cnt <= `BITCNT_ZERO;
              if (state == ST_ADDR)
              begin
                if (addr_match)
                begin
                  in_ack <= 1'b1;
                  sda_oe_n_out <= 1'b0;
                  if (shift[0] == `RW_READ)
                  begin
                    state <= ST_RDATA;
                    tx_byte <= read_byte(pointer, channel_power_state,
                      strap_address_readback, channel_mode_select);
                  end
                  else
                    state <= ST_CMD;
                end
                else
                  state <= ST_IDLE;
              end
              else if (state == ST_CMD)
              begin
                pointer <= shift;
                in_ack <= 1'b1;
                sda_oe_n_out <= 1'b0;
                state <= ST_WDATA;
              end
              else
              begin
                // writes to read-only codes are acknowledged and dropped
                if (pointer == `CMD_MODE_SELECT)
                  channel_mode_select <= shift;
                pointer <= next_pointer;
                in_ack <= 1'b1;
                sda_oe_n_out <= 1'b0;
              end
            end
          end
          ST_RDATA:
          begin
            if (scl_fall & in_ack)
            begin
              in_ack <= 1'b0;
              sda_oe_n_out <= tx_byte[`TX_MSB];
            end
            // the rise of the ack clock is not a data bit
            else if (scl_rise & ~in_ack)
              bit_cnt <= bit_cnt + `BITCNT_STEP;
            else if (scl_fall & (bit_cnt == `BITS_PER_BYTE))
            begin
              sda_oe_n_out <= 1'b1;
              bit_cnt <= `BITCNT_ZERO;
              state <= ST_RACK;
            end
            else if (scl_fall)
              sda_oe_n_out <= tx_byte[`TX_MSB - bit_cnt[2:0]];
          end
          ST_RACK:
          begin
            if (scl_rise)
            begin
              if (~sda_in)
              begin
                pointer <= next_pointer;
                tx_byte <= read_byte(next_pointer, channel_power_state,
                  strap_address_readback, channel_mode_select);
                in_ack <= 1'b1;
                state <= ST_RDATA;
              end
              else
                state <= ST_IDLE;
            end
          end
          default:
          begin
            in_ack <= 1'b0;
            sda_oe_n_out <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule

//--- sim/pse_regs_sva.sv
`timescale 1ns/1ps
module pse_regs_sva (
  input wire ref_clk_in, // device clock
  input wire reset_in, // synchronous reset
  input wire [3:0] channel_on_in, // sequencer on request
  input wire [3:0] turn_on_done_in, // turn-on complete
  input wire [3:0] drain_sense_pin_in, // drain below threshold
  input wire [1:0] four_pair_wired_in, // pair wiring
  input wire [1:0] single_signature_in, // single signature pair
  input wire [3:0] power_good_flags_out, // good flags
  input wire [3:0] channel_on_flags_out, // on flags
  input wire [3:0] channel_on_change_event_out, // on change pulses
  input wire [3:0] power_good_change_event_out, // good change pulses
  input wire [7:0] channel_mode_out // mode register
);
  wire [3:0] mode_nz;
  assign mode_nz = {|channel_mode_out[7:6], |channel_mode_out[5:4],
    |channel_mode_out[3:2], |channel_mode_out[1:0]};
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);
  a_on_follows: assert property (!$past(reset_in) |->
    channel_on_flags_out == $past(channel_on_in & mode_nz))
    else $error("on flags do not follow request and mode");
  a_pg_needs_on: assert property (
    (power_good_flags_out & ~channel_on_flags_out) == 4'h0)
    else $error("good flag set on an off channel");
  a_pg_holds: assert property (!$past(reset_in) |->
    ($past(power_good_flags_out) & channel_on_flags_out
    & ~power_good_flags_out) == 4'h0)
    else $error("good flag dropped while channel on");
  a_pg_cause: assert property (!$past(reset_in) |->
    (power_good_flags_out & ~$past(power_good_flags_out)
    & ~$past(turn_on_done_in & drain_sense_pin_in)) == 4'h0)
    else $error("good flag rose without drain and done");
  a_single_pair: assert property (!$past(reset_in)
    && $rose(power_good_flags_out[0])
    && $past(four_pair_wired_in[0] & single_signature_in[0])
    |-> $past(channel_on_in[1] & turn_on_done_in[1]
    & drain_sense_pin_in[1]))
    else $error("single signature good flag rose early");
  a_on_event: assert property (!$past(reset_in) |->
    channel_on_change_event_out
    == (channel_on_flags_out ^ $past(channel_on_flags_out)))
    else $error("on change event wrong");
  a_pg_event: assert property (!$past(reset_in) |->
    power_good_change_event_out
    == (power_good_flags_out ^ $past(power_good_flags_out)))
    else $error("good change event wrong");
  a_reset_clear: assert property (disable iff (1'b0)
    reset_in |=> channel_mode_out == 8'h00
    && channel_on_flags_out == 4'h0)
    else $error("reset did not clear mode and flags");
  c_pg_rise: cover property ($rose(power_good_flags_out[0]));
  c_on_event: cover property (channel_on_change_event_out != 4'h0);
  c_auto_mode: cover property (channel_mode_out == 8'hFF);
endmodule

//--- sim/i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model (
  input wire ref_clk_in, // device clock
  input wire sda_line_in, // resolved serial data level
  output reg scl_out, // serial clock, idles high
  output reg sda_low_out // set to pull serial data low
);
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // two clocks a phase since the slave oversamples the bus
  task tick;
    begin
      repeat (2) @(posedge ref_clk_in);
    end
  endtask
  task start_cond;
    begin
      sda_low_out <= 1'b0;
      tick;
      scl_out <= 1'b1;
      tick;
      sda_low_out <= 1'b1;
      tick;
      scl_out <= 1'b0;
      tick;
    end
  endtask
  task stop_cond;
    begin
      sda_low_out <= 1'b1;
      tick;
      scl_out <= 1'b1;
      tick;
      sda_low_out <= 1'b0;
      tick;
    end
  endtask
  // sampled at the edge that lowers scl, while the slave still holds data
  task bit_io(input b, output r);
    begin
      sda_low_out <= ~b;
      tick;
      scl_out <= 1'b1;
      tick;
      r = sda_line_in;
      scl_out <= 1'b0;
      tick;
    end
  endtask
  task xfer(input [7:0] tx, input ack_in, output [7:0] rx, output nak);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bit_io(tx[i], rx[i]);
      bit_io(ack_in, nak);
    end
  endtask
endmodule

//--- sim/tb_pse_channel_status_mode_regs.sv
`timescale 1ns/1ps
module tb_pse_channel_status_mode_regs;
  reg ref_clk_in = 1'b0;
  reg reset_in = 1'b1;
  reg config_b_in = 1'b0;
  reg [3:0] strap = 4'hA;
  reg [3:0] on_req = 4'h0, done = 4'h0, drain = 4'h0, alloc = 4'h0;
  reg [1:0] wired = 2'h0, single = 2'h0;
  reg [15:0] mclass = 16'h0000;
  wire scl, host_low, sda_oe_n, sda_line, sda_drv;
  wire [3:0] pg, on_f;
  wire [15:0] req_cls, asg_cls;
  integer miscompares = 0;
  integer compares = 0;
  // open-drain line with a pull-up
  assign sda_line = host_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_drv);
  always #12.5 ref_clk_in = ~ref_clk_in;
  pse_channel_status_mode_regs #(.BANK_SELECT(1'b1)) u_dut (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .ce_in(1'b1),
    .config_b_in(config_b_in), .address_strap_pins_in(strap),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_drv),
    .sda_oe_n_out(sda_oe_n), .channel_on_in(on_req),
    .turn_on_done_in(done), .drain_sense_pin_in(drain),
    .four_pair_wired_in(wired), .single_signature_in(single),
    .alloc_lowest_in(alloc), .measured_class_in(mclass),
    .power_good_flags_out(pg), .channel_on_flags_out(on_f),
    .channel_on_change_event_out(), .power_good_change_event_out(),
    .channel_mode_out(), .requested_class_out(req_cls),
    .assigned_class_out(asg_cls));
  i2c_host_model u_host (.ref_clk_in(ref_clk_in), .sda_line_in(sda_line),
    .scl_out(scl), .sda_low_out(host_low));
  task chk(input [15:0] got, input [15:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp)
      begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
          exp);
      end
    end
  endtask
  task reg_write(input [6:0] a, input [7:0] c, input [7:0] d);
    reg [7:0] r;
    reg k;
    begin
      u_host.start_cond;
      u_host.xfer({a, 1'b0}, 1'b1, r, k);
      u_host.xfer(c, 1'b1, r, k);
      u_host.xfer(d, 1'b1, r, k);
      u_host.stop_cond;
    end
  endtask
  task reg_read(input [6:0] a, input [7:0] c, input [7:0] exp, input ack);
    reg [7:0] r;
    reg k;
    begin
      u_host.start_cond;
      u_host.xfer({a, 1'b0}, 1'b1, r, k);
      chk({15'h0, ~k}, {15'h0, ack});
      u_host.xfer(c, 1'b1, r, k);
      u_host.start_cond;
      u_host.xfer({a, 1'b1}, 1'b1, r, k);
      u_host.xfer(8'hFF, 1'b1, r, k);
      u_host.stop_cond;
      chk({8'h0, r}, {8'h0, exp});
    end
  endtask
  task settle;
    begin
      repeat (3) @(posedge ref_clk_in);
    end
  endtask
  task close_out;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial
  begin
    repeat (3) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    reg_read(7'h35, 8'h10, 8'h00, 1'b1);
    reg_read(7'h35, 8'h12, 8'h00, 1'b1);
    reg_read(7'h35, 8'h11, 8'h54, 1'b1);
    reg_read(7'h34, 8'h12, 8'hFF, 1'b0);
    config_b_in <= 1'b1;
    reg_read(7'h7F, 8'h11, 8'h50, 1'b1);
    config_b_in <= 1'b0;
    $display("test reset_and_address done");
    on_req <= 4'hF;
    done <= 4'hF;
    drain <= 4'hF;
    reg_write(7'h35, 8'h12, 8'hE4);
    reg_read(7'h35, 8'h12, 8'hE4, 1'b1);
    chk({12'h0, on_f}, 16'h000E);
    reg_read(7'h35, 8'h10, 8'hEE, 1'b1);
    $display("test mode_fields done");
    drain <= 4'h0;
    on_req <= 4'hD;
    settle;
    chk({12'h0, pg}, 16'h000C);
    reg_read(7'h35, 8'h10, 8'hCC, 1'b1);
    reg_write(7'h35, 8'h12, 8'h00);
    chk({8'h0, pg, on_f}, 16'h0000);
    $display("test turn_off done");
    on_req <= 4'hF;
    drain <= 4'hF;
    done <= 4'hD;
    wired <= 2'h3;
    single <= 2'h1;
    reg_write(7'h35, 8'h12, 8'hFF);
    settle;
    chk({12'h0, pg}, 16'h000C);
    done <= 4'hF;
    settle;
    chk({12'h0, pg}, 16'h000F);
    $display("test four_pair done");
    mclass <= 16'h5864;
    alloc <= 4'h1;
    settle;
    chk(req_cls, 16'h586C);
    chk(asg_cls, 16'h3834);
    $display("test class_report done");
    strap <= 4'h5;
    reset_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    reg_read(7'h2B, 8'h11, 8'h2C, 1'b1);
    reg_read(7'h2B, 8'h12, 8'h00, 1'b1);
    reg_read(7'h35, 8'h12, 8'hFF, 1'b0);
    $display("test strap_reset done");
    close_out;
  end
  initial
  begin
    repeat (30000) @(posedge ref_clk_in);
    miscompares = miscompares + 1;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    close_out;
  end
endmodule
bind pse_channel_status_mode_regs pse_regs_sva u_sva (
  .ref_clk_in(ref_clk_in), .reset_in(reset_in),
  .channel_on_in(channel_on_in), .turn_on_done_in(turn_on_done_in),
  .drain_sense_pin_in(drain_sense_pin_in),
  .four_pair_wired_in(four_pair_wired_in),
  .single_signature_in(single_signature_in),
  .power_good_flags_out(power_good_flags_out),
  .channel_on_flags_out(channel_on_flags_out),
  .channel_on_change_event_out(channel_on_change_event_out),
  .power_good_change_event_out(power_good_change_event_out),
  .channel_mode_out(channel_mode_out));
